/* shared/ssid_pkg.sv */
// constants, register map and carriers for the station id loader
package ssid_pkg;

  localparam int ID_W = 7;
  localparam int DIGIT_W = 4;
  localparam int NODE_W = 14;
  localparam int CRC_W = 32;
  localparam int AW = 8;

  localparam logic [ID_W-1:0] DIGIT_WEIGHT = 7'h0a;
  localparam logic [NODE_W-1:0] NODE_MULT = 14'h0064;
  localparam logic [NODE_W-1:0] AXIS1_OFS = 14'h0001;
  localparam logic [NODE_W-1:0] AXIS2_OFS = 14'h0002;
  localparam logic [ID_W-1:0] FACTORY_ID = 7'h01;
  localparam logic [ID_W-1:0] ID_NONE = 7'h00;

  // settle time for the switch synchronisers before the one-time latch
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_NS = 10000;
  localparam int SETTLE_CYC =
    (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_W = $clog2(SETTLE_CYC + 1);

  localparam logic [AW-1:0] REG_STATUS = 8'h00;
  localparam logic [AW-1:0] REG_NODE = 8'h04;
  localparam logic [AW-1:0] REG_CTRL = 8'h08;
  localparam logic [AW-1:0] REG_DATA = 8'h0c;
  localparam logic [AW-1:0] REG_MCRC = 8'h10;
  localparam logic [AW-1:0] REG_CALC = 8'h14;
  localparam logic [AW-1:0] REG_SRC = 8'h18;
  localparam logic [AW-1:0] REG_FR = 8'h1c;

  localparam int CTRL_NVCLR = 0;
  localparam int CTRL_BEGIN = 1;
  localparam int CTRL_SRCFB = 2;
  localparam int CTRL_VALID = 3;
  localparam int CTRL_RESTART = 4;

  localparam int ST_ZERO = 7;
  localparam int ST_CFG = 8;
  localparam int ST_PERS = 11;
  localparam int ST_OPER = 12;
  localparam int ST_NVP = 13;
  localparam int ST_CRCFAIL = 14;
  localparam int ST_REFUSED = 15;
  localparam int ST_BOOTED = 16;
  localparam int NODE_AX2_LSB = 16;

  // fault reaction 0 is torque off, 1 is controlled stop one, instance 1
  localparam int NUM_FR_DEF = 4;
  localparam logic [1:0] FR_FORCED = 2'h3;

  typedef enum logic [1:0] {
    B_SETTLE = 2'b01,
    B_RUN = 2'b10
  } ssid_boot_t;

  typedef enum logic [2:0] {
    C_NONE = 3'b001,
    C_LOADED = 3'b010,
    C_VALID = 3'b100
  } ssid_cfg_t;

  // stored image: the set and the id it is bound to
  typedef struct packed {
    logic valid;
    logic factory;
    logic [ID_W-1:0] bound_id;
    logic [CRC_W-1:0] crc;
  } ssid_nv_t;

endpackage : ssid_pkg

/* src/ssid_config.sv */
// station id loader, node addresses and safety parameter set validity
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/100ps
module ssid_config
  import ssid_pkg::*;
#(
  parameter int NUM_INST = 8,
  parameter int NUM_FR = NUM_FR_DEF
)(
  input wire logic pclk, // system clock
  input wire logic presetn, // power-on reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [AW-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic [DIGIT_W-1:0] tens_digit_switch, // rotary, tens
  input wire logic [DIGIT_W-1:0] units_digit_switch, // rotary, units
  input wire ssid_nv_t nv_image, // stored set, stable from reset
  output ssid_nv_t nv_wr, // store request, valid is a pulse
  output logic nv_clr, // erase stored set, pulse
  input wire logic [NUM_INST-1:0] safe_din, // safe inputs, pins
  input wire logic [NUM_INST-1:0] fieldbus_req, // fieldbus demands
  input wire logic [NUM_INST-1:0] fn_event, // function events
  input wire logic io_fail, // io failure
  input wire logic internal_fail, // critical internal failure
  output logic [ID_W-1:0] safety_station_id, // latched id
  output logic [NODE_W-1:0] node_addr_ax1, // node address axis 1
  output logic [NODE_W-1:0] node_addr_ax2, // node address axis 2
  output logic operational, // set valid and usable
  output logic [NUM_INST-1:0] instance_active, // selected demand
  output logic [NUM_FR-1:0] fault_reaction // fired reactions
);
  ssid_boot_t boot_state;
  ssid_cfg_t cfg_state;
  logic [SETTLE_W-1:0] settle_cnt;
  logic [DIGIT_W-1:0] tens_s1, tens_s2, units_s1, units_s2;
  logic [NUM_INST-1:0] din_s1, din_s2;
  logic [ID_W-1:0] id_calc, nv_bound;
  logic latch_now, persistent, src_fb, nv_present, crc_fail, refused;
  logic [CRC_W-1:0] crc_acc, master_crc;
  logic [NUM_INST-1:0] src_sel;
  logic [NUM_FR-1:0] fr_en, fr_eff;
  logic acc_phase, wr_go, rd_take, mapped;
  logic wr_ctrl, wr_data, do_clr, do_begin, do_valid, do_restart;
  logic fb_refused, crc_ok, fault_hit;
  logic [31:0] next_prdata;
  // switch digits pass two flops before anything reads them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      {tens_s1, tens_s2, units_s1, units_s2} <= '0;
    else
    begin
      {tens_s2, tens_s1} <= {tens_s1, tens_digit_switch};
      {units_s2, units_s1} <= {units_s1, units_digit_switch};
    end
  end
  assign id_calc = ({3'h0, tens_s2} * DIGIT_WEIGHT) + {3'h0, units_s2};
  assign latch_now = (boot_state == B_SETTLE) &&
                     (settle_cnt == SETTLE_W'(SETTLE_CYC));
  // factory image carries no id of its own: it belongs to id 01
  assign nv_bound = nv_image.factory ? FACTORY_ID : nv_image.bound_id;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      boot_state <= B_SETTLE;
      settle_cnt <= '0;
    end
    else
    begin
      case (boot_state)
        B_SETTLE:
        begin
          settle_cnt <= settle_cnt + SETTLE_W'(1);
          if (latch_now)
            boot_state <= B_RUN;
        end
        B_RUN: settle_cnt <= settle_cnt;
        default: boot_state <= B_SETTLE;
      endcase
    end
  end
  // taken once; later switch movement waits for the next power-up
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      safety_station_id <= ID_NONE;
      {node_addr_ax1, node_addr_ax2} <= '0;
    end
    else if (latch_now)
    begin
      safety_station_id <= id_calc;
      node_addr_ax1 <= NODE_W'({7'h0, id_calc} * NODE_MULT) + AXIS1_OFS;
      node_addr_ax2 <= NODE_W'({7'h0, id_calc} * NODE_MULT) + AXIS2_OFS;
    end
  end
  // apb: one wait state, answer registered
  assign acc_phase = psel && penable;
  assign wr_go = acc_phase && pready && pwrite;
  assign rd_take = acc_phase && !pready;
  always_comb
  begin
    mapped = 1'b1;
    next_prdata = '0;
    case (paddr)
      REG_STATUS:
      begin
        next_prdata[ID_W-1:0] = safety_station_id;
        next_prdata[ST_ZERO] = (safety_station_id == ID_NONE);
        next_prdata[ST_CFG +: 3] = cfg_state;
        next_prdata[ST_PERS] = persistent;
        next_prdata[ST_OPER] = operational;
        next_prdata[ST_NVP] = nv_present;
        next_prdata[ST_CRCFAIL] = crc_fail;
        next_prdata[ST_REFUSED] = refused;
        next_prdata[ST_BOOTED] = (boot_state == B_RUN);
      end
      REG_NODE:
      begin
        next_prdata[NODE_W-1:0] = node_addr_ax1;
        next_prdata[NODE_AX2_LSB +: NODE_W] = node_addr_ax2;
      end
      REG_CTRL, REG_DATA: next_prdata = '0;
      REG_MCRC: next_prdata = master_crc;
      REG_CALC: next_prdata = crc_acc;
      REG_SRC: next_prdata[NUM_INST-1:0] = src_sel;
      REG_FR: next_prdata[NUM_FR-1:0] = fr_eff;
      default: mapped = 1'b0;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      {pready, pslverr, prdata} <= '0;
    else
    begin
      pready <= rd_take;
      pslverr <= rd_take && !mapped;
      if (rd_take)
        prdata <= pwrite ? 32'h0 : next_prdata;
    end
  end
  assign wr_ctrl = wr_go && (paddr == REG_CTRL);
  assign wr_data = wr_go && (paddr == REG_DATA);
  assign do_clr = wr_ctrl && pwdata[CTRL_NVCLR];
  assign do_begin = wr_ctrl && pwdata[CTRL_BEGIN];
  assign do_valid = wr_ctrl && pwdata[CTRL_VALID];
  assign do_restart = wr_ctrl && pwdata[CTRL_RESTART];
  // fieldbus parametrisation needs an erased store first
  assign fb_refused = do_begin && pwdata[CTRL_SRCFB] && nv_present;
  assign crc_ok = (crc_acc == master_crc) &&
                  (safety_station_id != ID_NONE);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      {master_crc, src_sel, fr_en} <= '0;
    else if (wr_go)
    begin
      if (paddr == REG_MCRC)
        master_crc <= pwdata;
      if (paddr == REG_SRC)
        src_sel <= pwdata[NUM_INST-1:0];
      if (paddr == REG_FR)
        fr_en <= pwdata[NUM_FR-1:0];
    end
  end
  // torque off and stop one cannot be switched off by software
  assign fr_eff = fr_en | NUM_FR'(FR_FORCED);
  // running checksum over the downloaded words
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      crc_acc <= '0;
    else if (do_begin && !fb_refused)
      crc_acc <= '0;
    else if (wr_data && cfg_state == C_LOADED)
      crc_acc <= {crc_acc[CRC_W-2:0], crc_acc[CRC_W-1]} ^ pwdata;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_state <= C_NONE;
    else if (latch_now)
    begin
      if (id_calc != ID_NONE && nv_image.valid && nv_bound == id_calc)
        cfg_state <= C_VALID;
      else
        cfg_state <= C_NONE;
    end
    else if (boot_state == B_RUN)
    begin
      case (cfg_state)
        C_NONE:
          if (do_begin && !fb_refused)
            cfg_state <= C_LOADED;
        C_LOADED:
          if (do_restart && src_fb)
            cfg_state <= C_NONE;
          else if (do_valid && crc_ok)
            cfg_state <= C_VALID;
        C_VALID:
          if (do_restart && !persistent)
            cfg_state <= C_NONE;
          else if (do_clr && persistent)
            cfg_state <= C_NONE;
          else if (do_begin && !fb_refused)
            cfg_state <= C_LOADED;
        default: cfg_state <= C_NONE;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      {persistent, src_fb} <= 2'b00;
    else if (latch_now)
      persistent <= nv_image.valid && nv_bound == id_calc &&
                    id_calc != ID_NONE;
    else if (do_begin && !fb_refused)
    begin
      src_fb <= pwdata[CTRL_SRCFB];
      persistent <= 1'b0;
    end
    else if (do_valid && crc_ok && cfg_state == C_LOADED)
      persistent <= !src_fb;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      {crc_fail, refused} <= 2'b00;
    else
    begin
      if (do_valid)
        crc_fail <= !(crc_ok && cfg_state == C_LOADED);
      if (do_begin)
        refused <= fb_refused;
    end
  end
  // store side: erase on id change or 00, write persistent sets
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      {nv_clr, nv_wr, nv_present} <= '0;
    else
    begin
      nv_clr <= 1'b0;
      nv_wr.valid <= 1'b0;
      if (latch_now)
      begin
        // erasing, not just ignoring, keeps a restored id from reviving it
        if (nv_image.valid &&
            (id_calc == ID_NONE || nv_bound != id_calc))
        begin
          nv_clr <= 1'b1;
          nv_present <= 1'b0;
        end
        else
          nv_present <= nv_image.valid;
      end
      else if (do_clr)
      begin
        nv_clr <= 1'b1;
        nv_present <= 1'b0;
      end
      else if (do_valid && crc_ok && cfg_state == C_LOADED && !src_fb)
      begin
        nv_wr.valid <= 1'b1;
        nv_wr.factory <= 1'b0;
        nv_wr.bound_id <= safety_station_id;
        nv_wr.crc <= crc_acc;
        nv_present <= 1'b1;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      operational <= 1'b0;
    else
      operational <= (cfg_state == C_VALID) &&
                     (safety_station_id != ID_NONE) &&
                     (boot_state == B_RUN);
  end
  generate
    for (genvar i = 0; i < NUM_INST; i++)
    begin : g_inst
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          {din_s1[i], din_s2[i], instance_active[i]} <= 3'b000;
        else
        begin
          din_s1[i] <= safe_din[i];
          din_s2[i] <= din_s1[i];
          instance_active[i] <= src_sel[i] ? fieldbus_req[i]
                                           : din_s2[i];
        end
      end
    end
  endgenerate
  assign fault_hit = (|fn_event) || io_fail || internal_fail;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fault_reaction <= '0;
    else
      fault_reaction <= fr_eff & {NUM_FR{fault_hit}};
  end
  AST_ID_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
    latch_now |=> safety_station_id == $past(id_calc))
    else $error("station id not taken from the digits");
  AST_ID_FROZEN: assert property (@(posedge pclk) disable iff (!presetn)
    (boot_state == B_RUN) ##1 (boot_state == B_RUN)
      |-> $stable(safety_station_id))
    else $error("station id moved after power-up");
  AST_NODE: assert property (@(posedge pclk) disable iff (!presetn)
    (boot_state == B_RUN) ##1 1'b1
      |-> node_addr_ax2 == node_addr_ax1 + AXIS1_OFS
      && node_addr_ax1 ==
        NODE_W'({7'h0, safety_station_id} * NODE_MULT) + AXIS1_OFS)
    else $error("node address does not follow station id");
  AST_ZERO_ID: assert property (@(posedge pclk) disable iff (!presetn)
    operational |-> safety_station_id != ID_NONE)
    else $error("operational with id 00");
  AST_MISMATCH: assert property (@(posedge pclk) disable iff (!presetn)
    latch_now && nv_image.valid && nv_bound != id_calc |=> nv_clr ##1 !operational)
    else $error("id change did not erase the stored set");
  AST_OPER: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_state != C_VALID |=> !operational)
    else $error("operational without a validated set");
  AST_VOLATILE: assert property (@(posedge pclk) disable iff (!presetn)
    do_restart && cfg_state == C_VALID && !persistent && boot_state == B_RUN
      |=> cfg_state == C_NONE ##1 !operational)
    else $error("volatile set survived a stack restart");
  AST_CRC: assert property (@(posedge pclk) disable iff (!presetn)
    do_valid && cfg_state == C_LOADED && crc_acc != master_crc
      |=> cfg_state == C_LOADED && crc_fail)
    else $error("set accepted with a wrong checksum");
  AST_FORCED: assert property (@(posedge pclk) disable iff (!presetn)
    fault_hit |=> fault_reaction[1:0] == FR_FORCED)
    else $error("forced reactions did not fire");
  AST_PERSIST: assert property (@(posedge pclk) disable iff (!presetn)
    do_valid && crc_ok && cfg_state == C_LOADED && boot_state == B_RUN
      |=> nv_wr.valid == !$past(src_fb))
    else $error("persistence does not follow the download path");
endmodule : ssid_config

/* verification/ssid_config_tb.sv */
// self-checking bench for the station id loader
`timescale 1ns/100ps
module ssid_config_tb
  import ssid_pkg::*;
;
  localparam logic [31:0] W0 = 32'h1234abcd;
  localparam logic [31:0] W1 = 32'h0f0f0001;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] tens = 4'h0;
  logic [3:0] units = 4'h1;
  ssid_nv_t nv_image;
  ssid_nv_t nv_wr;
  logic nv_clr;
  logic [7:0] safe_din = '0;
  logic [7:0] fieldbus_req = '0;
  logic [7:0] fn_event = '0;
  logic io_fail = 1'b0;
  logic internal_fail = 1'b0;
  logic [ID_W-1:0] sid;
  logic [NODE_W-1:0] ax1;
  logic [NODE_W-1:0] ax2;
  logic operational;
  logic [7:0] inst_act;
  logic [3:0] fault_reaction;
  logic [31:0] rd;
  logic err;
  int fail_count = 0;
  int compares = 0;

  always #5 pclk = ~pclk;

  ssid_config ssid_config_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tens_digit_switch(tens),
    .units_digit_switch(units), .nv_image(nv_image), .nv_wr(nv_wr),
    .nv_clr(nv_clr), .safe_din(safe_din), .fieldbus_req(fieldbus_req),
    .fn_event(fn_event), .io_fail(io_fail), .internal_fail(internal_fail),
    .safety_station_id(sid), .node_addr_ax1(ax1), .node_addr_ax2(ax2),
    .operational(operational), .instance_active(inst_act),
    .fault_reaction(fault_reaction)
  );

  ssid_nv_model ssid_nv_model_i (
    .pclk(pclk), .nv_wr(nv_wr), .nv_clr(nv_clr), .nv_image(nv_image)
  );

  task automatic final_report();
    if (fail_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chb

  // entered just after a rising edge; holds the request until pready
  task automatic apb(input logic w, input logic [AW-1:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n == 20)
      fail_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdr(input logic [AW-1:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rdr

  // power cycle: switches are set under reset and taken at the end of the settle time after release
  task automatic boot(input logic [3:0] t, input logic [3:0] u);
    int n;
    n = 0;
    presetn <= 1'b0;
    tens <= t;
    units <= u;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    do
    begin
      repeat (50) @(posedge pclk);
      rdr(REG_STATUS);
      n++;
    end
    while (rd[ST_BOOTED] !== 1'b1 && n < 40);
    repeat (4) @(posedge pclk);
  endtask : boot

  task automatic chk_id(input int id);
    rdr(REG_NODE);
    chk({25'h0, sid}, id);
    chk(rd, ((id * 100 + 2) << 16) | (id * 100 + 1));
    chk({18'h0, ax1}, id * 100 + 1);
    chk({18'h0, ax2}, id * 100 + 2);
  endtask : chk_id

  function automatic logic [31:0] good();
    return {W0[30:0], W0[31]} ^ W1;
  endfunction : good

  task automatic load(input logic fb, input logic [31:0] crc);
    wr(REG_CTRL, (32'h1 << CTRL_BEGIN) | ({31'h0, fb} << CTRL_SRCFB));
    wr(REG_DATA, W0);
    wr(REG_DATA, W1);
    wr(REG_MCRC, crc);
    wr(REG_CTRL, 32'h1 << CTRL_VALID);
    repeat (3) @(posedge pclk);
    rdr(REG_STATUS);
  endtask : load

  task automatic t_factory();
    boot(4'h0, 4'h1);
    chk_id(1);
    chb(operational, 1'b1);
    rdr(REG_STATUS);
    chk({29'h0, rd[10:8]}, 32'h4);
  endtask : t_factory

  task automatic t_switch();
    tens <= 4'h9;
    units <= 4'h9;
    repeat (20) @(posedge pclk);
    chk({25'h0, sid}, 1);
    boot(4'h2, 4'h3);
    chk_id(23);
    chb(operational, 1'b0);
    chb(nv_image.valid, 1'b0);
    boot(4'h0, 4'h1);
    chb(operational, 1'b0);
  endtask : t_switch

  task automatic t_download();
    load(1'b0, good() ^ 32'h1);
    chb(rd[ST_CRCFAIL], 1'b1);
    chb(operational, 1'b0);
    load(1'b0, good());
    chb(operational, 1'b1);
    chb(nv_image.valid, 1'b1);
    chk({25'h0, nv_image.bound_id}, 1);
    chk(nv_image.crc, good());
    rdr(REG_CALC);
    chk(rd, good());
    boot(4'h0, 4'h1);
    chb(operational, 1'b1);
  endtask : t_download

  task automatic t_fieldbus();
    load(1'b1, good());
    chb(rd[ST_REFUSED], 1'b1);
    wr(REG_CTRL, 32'h1 << CTRL_NVCLR);
    repeat (3) @(posedge pclk);
    chb(nv_image.valid, 1'b0);
    load(1'b1, good());
    chb(operational, 1'b1);
    chb(rd[ST_PERS], 1'b0);
    chb(nv_image.valid, 1'b0);
    wr(REG_CTRL, 32'h1 << CTRL_RESTART);
    repeat (3) @(posedge pclk);
    chb(operational, 1'b0);
    load(1'b1, good());
    boot(4'h0, 4'h1);
    chb(operational, 1'b0);
  endtask : t_fieldbus

  task automatic t_zero();
    load(1'b0, good());
    boot(4'h0, 4'h0);
    chb(nv_image.valid, 1'b0);
    chk({25'h0, sid}, 0);
    load(1'b0, good());
    chb(rd[ST_ZERO], 1'b1);
    chb(operational, 1'b0);
    boot(4'h9, 4'h9);
    chk_id(99);
  endtask : t_zero

  task automatic t_misc();
    wr(REG_FR, 32'h0);
    rdr(REG_FR);
    chk({30'h0, rd[1:0]}, 32'h3);
    for (int s = 0; s < 4; s++)
    begin
      fn_event <= (s == 0) ? 8'h10 : 8'h00;
      io_fail <= (s == 1);
      internal_fail <= (s == 2);
      repeat (3) @(posedge pclk);
      chk({28'h0, fault_reaction}, (s < 3) ? 32'h3 : 32'h0);
    end
    wr(REG_SRC, 32'h1);
    fieldbus_req <= 8'h03;
    repeat (6) @(posedge pclk);
    chk({30'h0, inst_act[1:0]}, 32'h1);
    fieldbus_req <= 8'h00;
    safe_din <= 8'h02;
    repeat (6) @(posedge pclk);
    chk({30'h0, inst_act[1:0]}, 32'h2);
    rdr(8'h40);
    chk({err, rd[30:0]}, 32'h80000000);
  endtask : t_misc

  initial
  begin
    #400000;
    fail_count++;
    final_report();
  end

  initial
  begin
    t_factory();
    t_switch();
    t_download();
    t_fieldbus();
    t_zero();
    t_misc();
    final_report();
  end
endmodule : ssid_config_tb

/* verification/ssid_nv_model.sv */
// non-volatile parameter store that sits beside the station id loader
`timescale 1ns/100ps
module ssid_nv_model
  import ssid_pkg::*;
#(
  parameter logic [CRC_W-1:0] FACTORY_CRC = 32'h00005a5a // arbitrary value
)(
  input wire logic pclk, // system clock
  input wire ssid_nv_t nv_wr, // store request, valid is a pulse
  input wire logic nv_clr, // erase request, pulse
  output ssid_nv_t nv_image // stored image
);
  // shipped with the factory set bound to the preset id
  initial nv_image = '{1'b1, 1'b1, FACTORY_ID, FACTORY_CRC};
  // no reset: contents must outlive every power cycle
  always @(posedge pclk)
  begin
    if (nv_clr)
      nv_image <= '0;
    else if (nv_wr.valid)
      nv_image <= nv_wr;
  end
endmodule : ssid_nv_model
